/* rtl/fpc_map.vh */
// register offsets, field positions, reset values and timing counts
`ifndef FPC_MAP_VH
`define FPC_MAP_VH
`define FPC_CTRL_ADDR      8'hd1
`define FPC_STAT_ADDR      8'hd3
`define FPC_CTRL_RESET     8'h00
`define FPC_STAT_RESET     8'h00
`define FPC_LAUNCH_HI      7
`define FPC_LAUNCH_LO      4
`define FPC_MAP_BIT        3
`define FPC_SPACE_HI       2
`define FPC_SPACE_LO       1
`define FPC_BUSY_BIT       0
`define FPC_ERR_BIT        1
`define FPC_LOADED_BIT     0
`define FPC_UNLOCK_FIRST   4'h5
`define FPC_UNLOCK_SECOND  4'ha
`define FPC_SPACE_USER     2'b00
`define FPC_SPACE_XROW     2'b01
`define FPC_SPACE_SECURE   2'b10
`define FPC_SPACE_LATCHRST 2'b11
`define FPC_PROG_TIME_US   10
`define FPC_CLK_MHZ        50
`define FPC_PROG_CYCLES    (`FPC_PROG_TIME_US * `FPC_CLK_MHZ)
`define FPC_XROW_BASE      16'hff80
`endif

/* rtl/fpc_page_latch.v */
// one page of write-only column latch storage with valid marks
`timescale 1ns/1ps
module fpc_page_latch #(
    parameter ADDR_W = 7,
    parameter DATA_W = 8
) (
    input  wire              clk_sys_in,  // core clock
    input  wire              sys_rst_in,  // async reset, high
    input  wire              clear_in,    // drop all valid marks
    input  wire              wr_in,       // write one byte
    input  wire [ADDR_W-1:0] wr_addr_in,  // byte within page
    input  wire [DATA_W-1:0] wr_data_in,  // byte to store
    input  wire [ADDR_W-1:0] rd_addr_in,  // byte for programming
    output wire [DATA_W-1:0] rd_data_out, // stored byte
    output wire              rd_vld_out   // byte was loaded
);
    localparam DEPTH = 1 << ADDR_W;
    reg [DATA_W-1:0] mem [0:DEPTH-1];
    reg [DEPTH-1:0]  vld;

    always @(posedge clk_sys_in)
    begin
        if (wr_in)
            mem[wr_addr_in] <= wr_data_in;
    end

    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            vld <= {DEPTH{1'b0}};
        else
        begin
            // a load in the clearing cycle survives the clear
            if (clear_in)
                vld <= {DEPTH{1'b0}};
            if (wr_in)
                vld[wr_addr_in] <= 1'b1;
        end
    end

    assign rd_data_out = mem[rd_addr_in];
    assign rd_vld_out  = vld[rd_addr_in];
endmodule // fpc_page_latch

/* rtl/fpc_flash_program_control.v */
// flash programming control and status registers with page latch
// Contract
// - launch needs nibble 5 then A
// - map bit steers stores into page latch
// - busy set during program, software cannot write
// - both registers reset to zero
// - wrong launch order sets order error
// - error cleared by software or good launch
// - first latch byte sets loaded flag
// - successful launch clears loaded flag
// - code reads return selected region, read-only
// - low 7 bits byte, high 9 bits page
// - map bit overrides external ram select
// - space select picks array, row, byte, reset
// - code reads follow current space select
// - first nibble alone does nothing
// - 512 pages of 128 bytes
// - latch loads only from boot or external code
`timescale 1ns/1ps
`include "fpc_map.vh"
module fpc_flash_program_control #(
    parameter PAGE_W     = 7,
    parameter PAGES_W    = 9,
    parameter PROG_CYCLES = `FPC_PROG_CYCLES
) (
    input  wire        clk_sys_in,        // core clock, 50 MHz
    input  wire        sys_rst_in,        // async reset, high
    input  wire        sfr_wr_in,         // special register write
    input  wire [7:0]  sfr_addr_in,       // special register address
    input  wire [7:0]  sfr_wdata_in,      // special register write data
    input  wire        sfr_rd_in,         // special register read
    output reg  [7:0]  sfr_rdata_out,     // read data, one cycle later
    output reg         sfr_hit_out,       // read hit this block
    input  wire        xst_in,            // external data store
    input  wire [15:0] xst_addr_in,       // store address
    input  wire [7:0]  xst_data_in,       // store data
    input  wire        external_ram_select_in, // aux ram select
    input  wire        exec_boot_in,      // code runs from boot flash
    input  wire        exec_ext_in,       // code runs from ext memory
    output reg         xst_to_xdata_out,  // store goes to data space
    output reg         xst_to_eram_out,   // store goes to internal ram
    output reg         xst_to_latch_out,  // store taken by latch
    input  wire        code_rd_in,        // code read via pointer
    input  wire [15:0] code_addr_in,      // code read address
    output reg  [1:0]  code_space_out,    // region for code read
    output reg  [15:0] code_array_addr_out, // address into region
    output reg         code_rd_out,       // read forwarded, read-only
    output reg         prog_start_out,    // programming started pulse
    output reg  [1:0]  prog_space_out,    // region being programmed
    output reg  [8:0]  prog_page_out,     // page being programmed
    output reg  [6:0]  prog_byte_addr_out,// byte being sent
    output reg  [7:0]  prog_byte_data_out,// byte data
    output reg         prog_byte_vld_out  // byte strobe, loaded bytes
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_ARMED = 2'd1;
    localparam ST_PROG  = 2'd2;
    localparam CNT_W    = 16;
    localparam integer     PROG_M1   = PROG_CYCLES - 1;
    localparam [CNT_W-1:0] PROG_LAST = PROG_M1[CNT_W-1:0];
    localparam [PAGE_W-1:0] BYTE_LAST = {PAGE_W{1'b1}};

    reg [1:0]         state;
    reg [1:0]         next_state;
    reg               map_sel;
    reg [1:0]         space_sel;
    reg [3:0]         nibble;
    reg               busy;
    reg               order_err;
    reg               loaded;
    reg [PAGES_W-1:0] page;
    reg [CNT_W-1:0]   cnt;
    reg [PAGE_W-1:0]  step;
    reg               launch_ok;
    reg               launch_bad;

    wire ctrl_wr = sfr_wr_in && (sfr_addr_in == `FPC_CTRL_ADDR);
    wire stat_wr = sfr_wr_in && (sfr_addr_in == `FPC_STAT_ADDR);
    wire [3:0] wr_nib = sfr_wdata_in[`FPC_LAUNCH_HI:`FPC_LAUNCH_LO];
    wire [1:0] wr_space = sfr_wdata_in[`FPC_SPACE_HI:`FPC_SPACE_LO];
    // latch store: map bit wins over aux ram select
    wire latch_wr = xst_in && map_sel && !busy &&
                    (exec_boot_in || exec_ext_in);
    wire [7:0] lat_rdata;
    wire       lat_rvld;
    // latches dropped by a latch reset launch or once a page is written
    wire       lat_clear = (launch_ok && wr_space == `FPC_SPACE_LATCHRST) ||
                           (state == ST_PROG && next_state == ST_IDLE);

    fpc_page_latch #(
        .ADDR_W (PAGE_W),
        .DATA_W (8)
    ) u_latch (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .clear_in   (lat_clear),
        .wr_in      (latch_wr),
        .wr_addr_in (xst_addr_in[PAGE_W-1:0]),
        .wr_data_in (xst_data_in),
        .rd_addr_in (step),
        .rd_data_out(lat_rdata),
        .rd_vld_out (lat_rvld)
    );

    // launch decode: 5 arms, A after 5 fires, A unarmed or a nibble other than 5 or A after 5 is an error
    always @*
    begin
        launch_ok  = 1'b0;
        launch_bad = 1'b0;
        next_state = state;
        if (ctrl_wr && state != ST_PROG)
        begin
            if (state == ST_ARMED && wr_nib == `FPC_UNLOCK_SECOND)
            begin
                launch_ok  = 1'b1;
                next_state = (wr_space == `FPC_SPACE_LATCHRST) ?
                             ST_IDLE : ST_PROG;
            end
            else if (wr_nib == `FPC_UNLOCK_FIRST)
                next_state = ST_ARMED;
            else if (state == ST_ARMED || wr_nib == `FPC_UNLOCK_SECOND)
            begin
                launch_bad = 1'b1;
                next_state = ST_IDLE;
            end
        end
        else if (state == ST_PROG && cnt == PROG_LAST &&
                 step == BYTE_LAST)
            next_state = ST_IDLE;
    end

    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state     <= ST_IDLE;
            map_sel   <= 1'b0;
            space_sel <= `FPC_SPACE_USER;
            nibble    <= 4'h0;
            busy      <= 1'b0;
            order_err <= 1'b0;
            loaded    <= 1'b0;
            page      <= {PAGES_W{1'b0}};
            cnt       <= {CNT_W{1'b0}};
            step      <= {PAGE_W{1'b0}};
        end
        else
        begin
            state <= next_state;
            if (ctrl_wr && state != ST_PROG)
            begin
                nibble    <= wr_nib;
                map_sel   <= sfr_wdata_in[`FPC_MAP_BIT];
                space_sel <= wr_space;
            end
            busy <= (next_state == ST_PROG);
            if (launch_bad)
                order_err <= 1'b1;
            else if (launch_ok)
                order_err <= 1'b0;
            else if (stat_wr && !sfr_wdata_in[`FPC_ERR_BIT])
                order_err <= 1'b0;
            if (latch_wr)
                loaded <= 1'b1;
            else if (launch_ok)
                loaded <= 1'b0;
            if (latch_wr)
                page <= xst_addr_in[15:PAGE_W];
            if (launch_ok || state != ST_PROG)
            begin
                cnt  <= {CNT_W{1'b0}};
                step <= {PAGE_W{1'b0}};
            end
            else if (cnt == PROG_LAST)
            begin
                cnt  <= {CNT_W{1'b0}};
                step <= step + 1'b1;
            end
            else
                cnt <= cnt + 1'b1;
        end
    end

    // registered outputs
    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sfr_rdata_out       <= 8'h00;
            sfr_hit_out         <= 1'b0;
            xst_to_xdata_out    <= 1'b0;
            xst_to_eram_out     <= 1'b0;
            xst_to_latch_out    <= 1'b0;
            code_space_out      <= `FPC_SPACE_USER;
            code_array_addr_out <= 16'h0000;
            code_rd_out         <= 1'b0;
            prog_start_out      <= 1'b0;
            prog_space_out      <= `FPC_SPACE_USER;
            prog_page_out       <= 9'h000;
            prog_byte_addr_out  <= 7'h00;
            prog_byte_data_out  <= 8'h00;
            prog_byte_vld_out   <= 1'b0;
        end
        else
        begin
            sfr_hit_out   <= sfr_rd_in &&
                             (sfr_addr_in == `FPC_CTRL_ADDR ||
                              sfr_addr_in == `FPC_STAT_ADDR);
            if (sfr_rd_in && sfr_addr_in == `FPC_CTRL_ADDR)
                sfr_rdata_out <= {nibble, map_sel, space_sel, busy};
            else if (sfr_rd_in && sfr_addr_in == `FPC_STAT_ADDR)
                sfr_rdata_out <= {6'h00, order_err, loaded};
            else
                sfr_rdata_out <= 8'h00;
            xst_to_latch_out <= latch_wr;
            xst_to_eram_out  <= xst_in && !map_sel &&
                                !external_ram_select_in;
            xst_to_xdata_out <= xst_in && !map_sel &&
                                external_ram_select_in;
            code_rd_out      <= code_rd_in;
            code_space_out   <= space_sel;
            case (space_sel)
                `FPC_SPACE_XROW:
                    code_array_addr_out <= `FPC_XROW_BASE |
                                           {9'h000, code_addr_in[6:0]};
                `FPC_SPACE_SECURE:
                    code_array_addr_out <= 16'h0000;
                default:
                    code_array_addr_out <= code_addr_in;
            endcase
            prog_start_out <= launch_ok &&
                              wr_space != `FPC_SPACE_LATCHRST;
            if (launch_ok)
            begin
                prog_space_out <= wr_space;
                prog_page_out  <= page;
            end
            prog_byte_vld_out  <= busy && cnt == PROG_LAST && lat_rvld;
            prog_byte_addr_out <= step;
            prog_byte_data_out <= lat_rdata;
        end
    end
endmodule // fpc_flash_program_control

/* tb/fpc_flash_program_control_monitor.sv */
// port checker for the flash programming control block
`timescale 1ns/1ps
module fpc_flash_program_control_monitor #(
    parameter PROG_CYCLES = 4
) (
    input wire       clk_sys_in,        // core clock
    input wire       sys_rst_in,        // async reset
    input wire       sfr_wr_in,         // register write
    input wire [7:0] sfr_addr_in,       // register address
    input wire [7:0] sfr_wdata_in,      // write data
    input wire       sfr_rd_in,         // register read
    input wire [7:0] sfr_rdata_out,     // read data
    input wire       sfr_hit_out,       // read hit
    input wire       xst_in,            // data store
    input wire       exec_boot_in,      // boot code running
    input wire       exec_ext_in,       // external code running
    input wire       xst_to_xdata_out,  // store to data space
    input wire       xst_to_eram_out,   // store to internal ram
    input wire       xst_to_latch_out,  // store to latch
    input wire       code_rd_in,        // code read
    input wire       code_rd_out,       // forwarded code read
    input wire       prog_start_out,    // start pulse
    input wire [1:0] prog_space_out,    // programmed region
    input wire [8:0] prog_page_out,     // programmed page
    input wire       prog_byte_vld_out  // byte strobe
);
    localparam int LIM = 128 * PROG_CYCLES + 4;
    int since;
    always @(posedge clk_sys_in or posedge sys_rst_in)
        if (sys_rst_in)
            since <= LIM + 1;
        else if (prog_start_out)
            since <= 0;
        else if (since <= LIM)
            since <= since + 1;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    a_hit_after_read: assert property (sfr_rd_in && (sfr_addr_in == 8'hd1
        || sfr_addr_in == 8'hd3) |=> sfr_hit_out) else $error("no read hit");
    a_rdata_idle_zero: assert property (!sfr_hit_out |-> sfr_rdata_out == 8'h00)
        else $error("read data not zero");
    a_start_needs_code: assert property (prog_start_out |->
        $past(sfr_wr_in && sfr_addr_in == 8'hd1 && sfr_wdata_in[7:4] == 4'ha)
        || $past(sfr_wr_in && sfr_addr_in == 8'hd1 && sfr_wdata_in[7:4] == 4'ha, 2))
        else $error("start without second nibble");
    a_no_latchrst_start: assert property (prog_start_out |-> prog_space_out != 2'b11)
        else $error("latch reset started programming");
    a_start_gap: assert property (prog_start_out |=> !prog_start_out [*8])
        else $error("start while busy");
    a_byte_window: assert property (prog_byte_vld_out |-> since <= LIM)
        else $error("byte strobe outside programming");
    a_steer_exclusive: assert property (xst_to_latch_out |-> $past(xst_in)
        && !xst_to_xdata_out && !xst_to_eram_out) else $error("store steered twice");
    a_latch_refused: assert property (xst_in && !exec_boot_in && !exec_ext_in
        |=> !xst_to_latch_out) else $error("latch load accepted");
    a_code_forward: assert property (code_rd_in |=> code_rd_out)
        else $error("code read not forwarded");
    a_page_stable: assert property (prog_byte_vld_out |-> $stable(prog_page_out))
        else $error("page moved while programming");
    c_start: cover property (prog_start_out);
    c_latch: cover property (xst_to_latch_out);
    c_byte: cover property (prog_byte_vld_out);
endmodule // fpc_flash_program_control_monitor
bind fpc_flash_program_control fpc_flash_program_control_monitor
    #(.PROG_CYCLES(PROG_CYCLES)) mon_i (.clk_sys_in, .sys_rst_in, .sfr_wr_in,
    .sfr_addr_in, .sfr_wdata_in, .sfr_rd_in, .sfr_rdata_out, .sfr_hit_out,
    .xst_in, .exec_boot_in, .exec_ext_in, .xst_to_xdata_out, .xst_to_eram_out,
    .xst_to_latch_out, .code_rd_in, .code_rd_out, .prog_start_out,
    .prog_space_out, .prog_page_out, .prog_byte_vld_out);

/* tb/fpc_core_model.sv */
// processor core model issuing register, store and code read cycles
`timescale 1ns/1ps
module fpc_core_model (
    input  wire clk_in            // core clock
);
    logic       wr, rd, xst, crd;
    logic [7:0] addr, wdata, xdata;
    logic [15:0] xaddr, caddr;
    initial {wr, rd, xst, crd, addr, wdata, xdata, xaddr, caddr} = '0;
    // one register cycle; data inverted once released
    task sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
        begin
            @(negedge clk_in);
            wr = w;
            rd = !w;
            addr = a;
            wdata = d;
            @(negedge clk_in);
            wr = 0;
            rd = 0;
            wdata = ~d;
        end
    endtask
    task store(input logic [15:0] a, input logic [7:0] d);
        begin
            @(negedge clk_in);
            xst = 1;
            xaddr = a;
            xdata = d;
            @(negedge clk_in);
            xst = 0;
            xdata = ~d;
        end
    endtask
    task code(input logic [15:0] a);
        begin
            @(negedge clk_in);
            crd = 1;
            caddr = a;
            @(negedge clk_in);
            crd = 0;
        end
    endtask
endmodule // fpc_core_model

/* tb/tb.sv */
// self-checking bench for the flash programming control block
`timescale 1ns/1ps
module tb;
    logic clk_sys_in, sys_rst_in, ers, eb, ee;
    wire [7:0] rdata, bd;
    wire [15:0] caa;
    wire [8:0] pg;
    wire [6:0] ba;
    wire [1:0] cs, psp;
    wire hit, tx, te, tl, co, ps, bv;
    int mismatches, n_tests, starts, bytes;
    logic [15:0] q[$];
    logic [15:0] a;
    logic [15:0] e;
    logic [7:0] d;
    logic [14:0] bq[$];
    fpc_core_model m (.clk_in(clk_sys_in));
    fpc_flash_program_control #(.PROG_CYCLES(4)) fpc_flash_program_control_i (
        .clk_sys_in, .sys_rst_in, .sfr_wr_in(m.wr), .sfr_addr_in(m.addr),
        .sfr_wdata_in(m.wdata), .sfr_rd_in(m.rd), .sfr_rdata_out(rdata),
        .sfr_hit_out(hit), .xst_in(m.xst), .xst_addr_in(m.xaddr),
        .xst_data_in(m.xdata), .external_ram_select_in(ers),
        .exec_boot_in(eb), .exec_ext_in(ee), .xst_to_xdata_out(tx),
        .xst_to_eram_out(te), .xst_to_latch_out(tl), .code_rd_in(m.crd),
        .code_addr_in(m.caddr), .code_space_out(cs),
        .code_array_addr_out(caa), .code_rd_out(co), .prog_start_out(ps),
        .prog_space_out(psp), .prog_page_out(pg), .prog_byte_addr_out(ba),
        .prog_byte_data_out(bd), .prog_byte_vld_out(bv));
    initial
    begin
        clk_sys_in = 0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp, input logic [7:0] k);
        begin
            n_tests++;
            if ((seen & k) !== (exp & k))
            begin
                mismatches++;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task rd(input logic [7:0] ad, input logic [7:0] exp, input logic [7:0] k);
        begin
            q.push_back({k, exp});
            m.sfr(0, ad, 8'h00);
        end
    endtask
    task wrap_up;
        begin
            if (q.size() != 0 || bq.size() != 0)
                mismatches++;
            $display("checks %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    always @(negedge clk_sys_in)
        if (hit === 1'b1)
        begin
            check(rdata, q[0][7:0], q[0][15:8]);
            void'(q.pop_front());
        end
    always @(negedge clk_sys_in)
    begin
        starts += (ps === 1'b1);
        bytes += (bv === 1'b1);
        if (bv === 1'b1)
        begin
            check({1'b0, ba}, {1'b0, bq[0][14:8]}, 8'hff);
            check(bd, bq[0][7:0], 8'hff);
            void'(bq.pop_front());
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        mismatches++;
        wrap_up;
    end
    initial
    begin
        {ers, eb, ee} = 3'b000;
        sys_rst_in = 1;
        repeat (16) @(posedge clk_sys_in);
        @(negedge clk_sys_in) sys_rst_in = 0;
        void'($urandom(75780));
        rd(8'hd1, 8'h00, 8'hff);
        rd(8'hd3, 8'h00, 8'hff);
        m.sfr(1, 8'hd1, 8'h08);
        m.store(16'h0000, 8'h11);
        check({5'h00, tl, te, tx}, 8'h00, 8'h04);
        rd(8'hd3, 8'h00, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            ers = (i != 1);
            ee = (i != 2);
            m.sfr(1, 8'hd1, {4'h0, i == 0, 3'b000});
            m.store(16'(($urandom)), 8'(($urandom)));
            check({5'h00, tl, te, tx}, {5'h00, i == 0, i == 1, i == 2}, 8'h07);
        end
        ee = 1;
        m.sfr(1, 8'hd1, 8'h5e);
        m.sfr(1, 8'hd1, 8'hae);
        rd(8'hd3, 8'h00, 8'h01);
        $display("steering test done");
        for (int s = 0; s < 4; s++)
        begin
            a = 16'($urandom);
            d = 8'($urandom);
            if (s < 3)
                bq.push_back({a[6:0], d});
            m.sfr(1, 8'hd1, {5'h01, 2'(s), 1'b0});
            m.store(a, d);
            rd(8'hd3, 8'h01, 8'h01);
            if (s == 0)
            begin
                m.sfr(1, 8'hd1, 8'h58);
                m.sfr(1, 8'hd1, 8'h38);
                rd(8'hd3, 8'h03, 8'h03);
                m.sfr(1, 8'hd3, 8'h00);
                rd(8'hd3, 8'h01, 8'h03);
                m.sfr(1, 8'hd1, 8'ha8);
                rd(8'hd3, 8'h03, 8'h03);
                check(8'(starts), 8'h00, 8'hff);
            end
            bytes = 0;
            m.sfr(1, 8'hd1, {4'h5, 1'b1, 2'(s), 1'b0});
            rd(8'hd1, 8'h00, 8'h01);
            m.sfr(1, 8'hd1, {4'ha, 1'b1, 2'(s), 1'b0});
            rd(8'hd1, {4'h0, 1'b1, 2'(s), s != 3}, 8'h0f);
            m.sfr(1, 8'hd1, {4'h0, 1'b1, 2'(s), 1'b0});
            rd(8'hd1, {4'h0, 1'b1, 2'(s), s != 3}, 8'h0f);
            rd(8'hd3, 8'h00, 8'h03);
            repeat (600) @(negedge clk_sys_in);
            rd(8'hd1, {4'h0, 1'b1, 2'(s), 1'b0}, 8'h0f);
            check(8'(starts), 8'(s < 3 ? s + 1 : 3), 8'hff);
            check(8'(bytes), 8'(s < 3), 8'hff);
            if (s < 3)
                check({pg[5:0], psp}, {a[12:7], 2'(s)}, 8'hff);
            a = 16'($urandom);
            e = (s == 2) ? 16'h0000 : a;
            if (s == 1)
                e = 16'hff80 | {9'h000, a[6:0]};
            m.code(a);
            check({6'h00, cs}, {6'h00, 2'(s)}, 8'h03);
            check(caa[15:8], e[15:8], 8'hff);
            check(caa[7:0], e[7:0], 8'hff);
            check({7'h00, co}, 8'h01, 8'h01);
            $display("space %0d test done", s);
        end
        wrap_up;
    end
endmodule // tb
